// ==== include/pth_pkg.sv ====
package pth_pkg;
  // Register byte offsets on the APB.
  localparam logic [7:0] ADDR_COUNT = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_LIMIT = 8'h0C;
  localparam logic [7:0] ADDR_EXTSEL = 8'h10;
  localparam logic [7:0] ADDR_IRQEN = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // Control register fields.
  localparam int CTRL_RUN_POS = 7;
  localparam int CTRL_PS_LSB = 4;
  localparam int CTRL_PS_MSB = 6;
  localparam int CTRL_POS_LSB = 0;
  localparam int CTRL_POS_MSB = 3;

  // Status register fields.
  localparam int STAT_FLAG_POS = 0;
  localparam int STAT_RUN_POS = 1;
  localparam int STAT_ARMED_POS = 2;

  // Reset values.
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [2:0] RST_PS = 3'h0;
  localparam logic [3:0] RST_POS = 4'h0;
  localparam logic [4:0] RST_MODE = 5'h00;
  localparam logic [4:0] RST_SEL = 5'h00;

  // Mode field groups in bits 4:3.
  localparam logic [1:0] GRP_FREE = 2'h0;
  localparam logic [1:0] GRP_ONESHOT = 2'h1;
  localparam logic [1:0] GRP_MONO = 2'h2;

  // Clock rate and the spacing the trigger source must keep, in timer clocks.
  localparam int CLK_PERIOD_NS = 40;
  localparam int EDGE_SPACING_TCLK = 6;
  localparam int LEVEL_HOLD_TCLK = 3;
  localparam logic [6:0] PRE_FULL = 7'h7F;
endpackage : pth_pkg

// ==== rtl/pth_sync.sv ====
`timescale 1ns/1ps
module pth_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous input
  input wire logic din,
  // Filtered level and edge pulses
  output logic lvl,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic stable;
    logic rise;
    logic fall;
  } pth_sync_type;

  pth_sync_type s_r;
  pth_sync_type s_nxt;

  // A change is accepted only once the second and third stages agree.
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = din;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    s_nxt.rise = 1'b0;
    s_nxt.fall = 1'b0;
    if (s_r.s2 == s_r.s3 && s_r.s3 != s_r.stable) begin
      s_nxt.stable = s_r.s3;
      s_nxt.rise = s_r.s3;
      s_nxt.fall = ~s_r.s3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lvl = s_r.stable;
  assign rise = s_r.rise;
  assign fall = s_r.fall;
endmodule : pth_sync

// ==== rtl/pth_timer.sv ====
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
// Function
// - Count advances by one on each prescaled timer clock while running.
// - Count equal to period drives match high and clears count next tick.
// - Reset gives count 00h and period FFh; both are read/write.
// - Count write, control write, reset or external reset clear both scalers.
// - A control write leaves the count unchanged.
// - Free-running: on match count returns to 00h and postscaler increments.
// - Postscaler equal to select gives one timer-clock pulse and clears.
// - One-shot: tick after match clears run bit and halts count at 00h.
// - One-shot restart resets the postscaler, so only select 0 matters.
// - Monostable: tick after match halts at 00h; run bit stays set except in codes 110, 111.
// - External input chosen by source select; mode field sets its role.
// - External trigger activity is ignored during debug freeze.
// - Free codes 000, 001, 010: software gate, high gate, low gate.
// - Free codes 011, 100, 101 reset on any, rising, falling edge.
// - Free codes 110, 111 hold count reset while input low or high.
// - One-shot 000 starts on run; 001-011 start on rising, falling, any edge.
// - One-shot 100-111 edge start with edge or level reset.
// - Edge-started modes need a fresh edge after run is set again.
// - Upper-10 codes 110, 111 level start, opposite level reset, stop at match.
// - Postscaler match raises period flag; irq only when enabled.
// - Prescaler divides the clock by 1 to 128.
module pth_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External trigger sources and debug
  input wire logic [31:0] ext_reset_input,
  input wire logic debug_freeze,
  // Timer outputs
  output logic postscaled_out,
  output logic period_irq,
  output logic timer_clock,
  // To the PWM unit
  output logic [7:0] timer_count,
  output logic period_match,
  output logic timer_reset_pulse
);
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] period;
    logic run;
    logic [2:0] ps;
    logic [3:0] pos;
    logic [4:0] mode;
    logic [4:0] sel;
    logic irq_en;
    logic flag;
    logic [6:0] pre;
    logic [3:0] post;
    logic armed;
    logic pend_r;
    logic pend_f;
    logic lvl;
    logic out_pulse;
    logic match;
    logic rst_pulse;
    logic tick;
    logic [31:0] rdata;
  } pth_state_type;

  pth_state_type s_r;
  pth_state_type s_nxt;

  logic ers_lvl;
  logic ers_rise;
  logic ers_fall;

  pth_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(ext_reset_input[s_r.sel]),
    .lvl(ers_lvl),
    .rise(ers_rise),
    .fall(ers_fall)
  );

  logic wr;
  logic setup;
  logic mapped;
  logic tick;
  logic [6:0] pre_max;
  logic [1:0] grp;
  logic [2:0] code;
  logic start_c;
  logic reset_c;
  logic en;
  logic match;
  logic fire;
  logic e_any;

  always_comb begin
    case (paddr)
      pth_pkg::ADDR_COUNT,
      pth_pkg::ADDR_PERIOD,
      pth_pkg::ADDR_CONTROL,
      pth_pkg::ADDR_LIMIT,
      pth_pkg::ADDR_EXTSEL,
      pth_pkg::ADDR_IRQEN,
      pth_pkg::ADDR_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign wr = psel & penable & pwrite & mapped;
  assign setup = psel & ~penable;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // The prescaler end value is a shifted mask, so every ratio is a power of two.
  assign pre_max = pth_pkg::PRE_FULL >> (3'h7 - s_r.ps);
  assign tick = (s_r.pre == pre_max);
  assign grp = s_r.mode[4:3];
  assign code = s_r.mode[2:0];
  assign match = (s_r.count == s_r.period);
  assign e_any = s_r.pend_r | s_r.pend_f;

  // Start and reset conditions for the selected mode.
  always_comb begin
    start_c = 1'b0;
    reset_c = 1'b0;
    en = 1'b0;
    case (grp)
      pth_pkg::GRP_FREE: begin
        case (code)
          3'h1: en = s_r.lvl;
          3'h2: en = ~s_r.lvl;
          3'h3: reset_c = e_any;
          3'h4: reset_c = s_r.pend_r;
          3'h5: reset_c = s_r.pend_f;
          3'h6: reset_c = ~s_r.lvl;
          3'h7: reset_c = s_r.lvl;
          default: en = 1'b1;
        endcase
        if (code >= 3'h3) begin
          en = ~reset_c;
        end
        en = en & s_r.run;
      end
      pth_pkg::GRP_ONESHOT: begin
        case (code)
          3'h0: start_c = 1'b1;
          3'h1: start_c = s_r.pend_r;
          3'h2: start_c = s_r.pend_f;
          3'h3: start_c = e_any;
          3'h4: begin
            start_c = s_r.pend_r;
            reset_c = s_r.armed & s_r.pend_r;
          end
          3'h5: begin
            start_c = s_r.pend_f;
            reset_c = s_r.armed & s_r.pend_f;
          end
          3'h6: begin
            start_c = s_r.pend_r;
            reset_c = ~s_r.lvl;
          end
          default: begin
            start_c = s_r.pend_f;
            reset_c = s_r.lvl;
          end
        endcase
        en = s_r.run & s_r.armed & ~reset_c;
      end
      pth_pkg::GRP_MONO: begin
        case (code)
          3'h1: start_c = s_r.pend_r;
          3'h2: start_c = s_r.pend_f;
          3'h3: start_c = e_any;
          3'h6: begin
            start_c = s_r.lvl;
            reset_c = ~s_r.lvl;
          end
          3'h7: begin
            start_c = ~s_r.lvl;
            reset_c = s_r.lvl;
          end
          default: start_c = 1'b0;
        endcase
        en = s_r.run & s_r.armed & ~reset_c;
      end
      default: en = 1'b0;
    endcase
    start_c = start_c & s_r.run;
    reset_c = reset_c & s_r.run;
  end

  assign fire = tick & en & match & (s_r.post == s_r.pos);

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = tick;
    s_nxt.pre = tick ? 7'h00 : s_r.pre + 7'h01;
    // While frozen the last accepted level is kept and edges are dropped.
    if (!debug_freeze) begin
      s_nxt.lvl = ers_lvl;
    end
    if (tick) begin
      s_nxt.pend_r = 1'b0;
      s_nxt.pend_f = 1'b0;
      s_nxt.out_pulse = fire;
      s_nxt.rst_pulse = reset_c;
      s_nxt.armed = s_r.armed | start_c;
      if (reset_c) begin
        s_nxt.count = pth_pkg::RST_COUNT;
        s_nxt.pre = 7'h00;
        s_nxt.post = 4'h0;
      end else if (en) begin
        if (match) begin
          s_nxt.count = pth_pkg::RST_COUNT;
          s_nxt.post = fire ? 4'h0 : s_r.post + 4'h1;
          if (grp != pth_pkg::GRP_FREE) begin
            s_nxt.armed = 1'b0;
          end
          if (grp == pth_pkg::GRP_ONESHOT || (grp == pth_pkg::GRP_MONO && code[2:1] == 2'h3)) begin
            s_nxt.run = 1'b0;
          end
        end else begin
          s_nxt.count = s_r.count + 8'h01;
        end
      end
    end
    if (!debug_freeze) begin
      s_nxt.pend_r = s_nxt.pend_r | ers_rise;
      s_nxt.pend_f = s_nxt.pend_f | ers_fall;
    end
    // With the run bit low every start is forgotten and stale edges are dropped.
    if (!s_r.run) begin
      s_nxt.armed = 1'b0;
      s_nxt.pend_r = 1'b0;
      s_nxt.pend_f = 1'b0;
    end
    // Hardware sets the flag after the software clear, so the set wins.
    if (wr && paddr == pth_pkg::ADDR_STATUS && pwdata[pth_pkg::STAT_FLAG_POS]) begin
      s_nxt.flag = 1'b0;
    end
    if (fire) begin
      s_nxt.flag = 1'b1;
    end
    if (wr) begin
      case (paddr)
        pth_pkg::ADDR_COUNT: begin
          s_nxt.count = pwdata[7:0];
          s_nxt.pre = 7'h00;
          s_nxt.post = 4'h0;
        end
        pth_pkg::ADDR_PERIOD: s_nxt.period = pwdata[7:0];
        pth_pkg::ADDR_CONTROL: begin
          // The count is deliberately left alone here.
          s_nxt.count = s_r.count;
          if (tick && (reset_c || (en && match))) begin
            s_nxt.count = pth_pkg::RST_COUNT;
          end else if (tick && en) begin
            s_nxt.count = s_r.count + 8'h01;
          end
          s_nxt.run = pwdata[pth_pkg::CTRL_RUN_POS];
          s_nxt.ps = pwdata[pth_pkg::CTRL_PS_MSB:pth_pkg::CTRL_PS_LSB];
          s_nxt.pos = pwdata[pth_pkg::CTRL_POS_MSB:pth_pkg::CTRL_POS_LSB];
          s_nxt.pre = 7'h00;
          s_nxt.post = 4'h0;
        end
        pth_pkg::ADDR_LIMIT: s_nxt.mode = pwdata[4:0];
        pth_pkg::ADDR_EXTSEL: s_nxt.sel = pwdata[4:0];
        pth_pkg::ADDR_IRQEN: s_nxt.irq_en = pwdata[0];
        default: s_nxt.irq_en = s_r.irq_en;
      endcase
    end
    s_nxt.match = (s_nxt.count == s_nxt.period);
    if (setup) begin
      case (paddr)
        pth_pkg::ADDR_COUNT: s_nxt.rdata = {24'h000000, s_r.count};
        pth_pkg::ADDR_PERIOD: s_nxt.rdata = {24'h000000, s_r.period};
        pth_pkg::ADDR_CONTROL: s_nxt.rdata = {24'h000000, s_r.run, s_r.ps, s_r.pos};
        pth_pkg::ADDR_LIMIT: s_nxt.rdata = {27'h0000000, s_r.mode};
        pth_pkg::ADDR_EXTSEL: s_nxt.rdata = {27'h0000000, s_r.sel};
        pth_pkg::ADDR_IRQEN: s_nxt.rdata = {31'h00000000, s_r.irq_en};
        pth_pkg::ADDR_STATUS: s_nxt.rdata = {29'h00000000, s_r.armed, s_r.run, s_r.flag};
        default: s_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.count <= pth_pkg::RST_COUNT;
      s_r.period <= pth_pkg::RST_PERIOD;
      s_r.ps <= pth_pkg::RST_PS;
      s_r.pos <= pth_pkg::RST_POS;
      s_r.mode <= pth_pkg::RST_MODE;
      s_r.sel <= pth_pkg::RST_SEL;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign postscaled_out = s_r.out_pulse;
  assign period_irq = s_r.flag & s_r.irq_en;
  assign timer_clock = s_r.tick;
  assign timer_count = s_r.count;
  assign period_match = s_r.match;
  assign timer_reset_pulse = s_r.rst_pulse;
endmodule : pth_timer

// ==== tb/pth_trig.sv ====
`timescale 1ns/1ps
module pth_trig #(
  parameter int HOLD = 6
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Level wanted by the bench
  input wire logic want,
  // Trigger lines
  output logic [31:0] ext_reset_input
);
  logic lvl_r;
  logic [3:0] hold_r;
  logic [30:0] junk_r;
  // A change is held back until the last one has stood long enough.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_r <= 1'b0;
      hold_r <= 4'hF;
      junk_r <= 31'h0;
    end else begin
      junk_r <= ~junk_r;
      if (want != lvl_r && hold_r >= 4'(HOLD)) begin
        lvl_r <= want;
        hold_r <= 4'h0;
      end else if (hold_r != 4'hF) begin
        hold_r <= hold_r + 4'h1;
      end
    end
  end
  // Unselected lines toggle so nothing can rely on them.
  assign ext_reset_input = {junk_r, lvl_r};
endmodule : pth_trig

// ==== tb/pth_timer_props.sv ====
`timescale 1ns/1ps
module pth_timer_props (
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // Timer outputs
  input wire logic postscaled_out,
  input wire logic period_irq,
  input wire logic [7:0] timer_count,
  input wire logic timer_clock,
  input wire logic period_match,
  input wire logic timer_reset_pulse
);
  logic wr;
  logic cnt_wr;
  logic en_r;
  logic [2:0] ps_r;
  logic [3:0] pos_r;
  logic [4:0] mode_r;
  logic [7:0] period_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign wr = psel && penable && pwrite;
  assign cnt_wr = wr && paddr == pth_pkg::ADDR_COUNT;
  // Shadow copies give the checks the programmed settings.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 1'b0;
      ps_r <= 3'h0;
      pos_r <= 4'h0;
      mode_r <= 5'h00;
      period_r <= pth_pkg::RST_PERIOD;
    end else if (wr) begin
      if (paddr == pth_pkg::ADDR_IRQEN) en_r <= pwdata[0];
      if (paddr == pth_pkg::ADDR_CONTROL) ps_r <= pwdata[6:4];
      if (paddr == pth_pkg::ADDR_CONTROL) pos_r <= pwdata[3:0];
      if (paddr == pth_pkg::ADDR_LIMIT) mode_r <= pwdata[4:0];
      if (paddr == pth_pkg::ADDR_PERIOD) period_r <= pwdata[7:0];
    end
  end
  sequence s_held_zero;
    (timer_count == 8'h00) [*2];
  endsequence
  chk_count_step: assert property ($changed(timer_count) && !$past(cnt_wr) |->
    timer_count == $past(timer_count) + 8'h01 || timer_count == 8'h00) else $error("count jumped");
  chk_count_write: assert property (cnt_wr |=> timer_count == $past(pwdata[7:0]))
    else $error("count write lost");
  chk_ctrl_stop: assert property (wr && paddr == pth_pkg::ADDR_CONTROL && !pwdata[7] |=> ##1
    $stable(timer_count)) else $error("count moved after stop");
  chk_post_width: assert property ($rose(postscaled_out) && ps_r == 3'h0 && pos_r != 4'h0
    |=> !postscaled_out) else $error("postscaled pulse too wide");
  chk_irq_enable: assert property (period_irq |-> en_r) else $error("irq while disabled");
  chk_irq_raise: assert property ($rose(postscaled_out) && en_r |-> ##[0:2] period_irq)
    else $error("irq missing");
  chk_unmapped_err: assert property (psel && penable && paddr > pth_pkg::ADDR_STATUS |-> pslverr)
    else $error("no error on unmapped");
  chk_oneshot_halt: assert property (mode_r == 5'h08 && timer_count == 8'h00 &&
    $past(timer_count) != 8'h00 && !$past(cnt_wr) |-> s_held_zero) else $error("one-shot ran on");
  chk_match_level: assert property (period_match == (timer_count == period_r))
    else $error("period match level wrong");
  chk_count_tick: assert property ($changed(timer_count) && !$past(cnt_wr) |-> timer_clock)
    else $error("count moved between timer clocks");
  chk_reset_zero: assert property ($rose(timer_reset_pulse) && !$past(cnt_wr) |-> timer_count == 8'h00)
    else $error("reset pulse without cleared count");
endmodule : pth_timer_props

// ==== tb/pth_timer_tb.sv ====
`timescale 1ns/1ps
module pth_timer_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dbg, want;
  logic postscaled_out, period_irq, post_q;
  logic [7:0] paddr, cnt;
  logic [31:0] pwdata, prdata, ext, d, e;
  int miscompares, total_checks, cyc, last, gap, npulse, n0;
  pth_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_reset_input(ext), .debug_freeze(dbg), .postscaled_out(postscaled_out),
    .period_irq(period_irq), .timer_clock(), .timer_count(cnt), .period_match(),
    .timer_reset_pulse());
  pth_trig u_trig (.pclk(pclk), .presetn(presetn), .want(want), .ext_reset_input(ext));
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;
  task print_verdict;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask : wr
  task rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  // Pulse spacing is measured here; a hang ends at the cycle ceiling.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict;
    end
    if (postscaled_out && !post_q) begin
      gap = cyc - last;
      last = cyc;
      npulse++;
    end
    post_q = postscaled_out;
  end
  initial begin
    {presetn, psel, penable, pwrite, dbg, want, post_q} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(pth_pkg::ADDR_COUNT); chk(d, 32'h0);
    rd(pth_pkg::ADDR_PERIOD); chk(d, 32'hFF);
    rd(8'h1C); chk(d, 32'h0);
    wr(pth_pkg::ADDR_IRQEN, 32'h1);
    wr(pth_pkg::ADDR_PERIOD, 32'h1);
    rd(pth_pkg::ADDR_PERIOD); chk(d, 32'h1);
    // Spacing of postscaled pulses is prescale times period times postscale.
    for (int i = 2; i >= 0; i--) begin
      wr(pth_pkg::ADDR_CONTROL, 32'h0);
      repeat (10) @(posedge pclk);
      wr(pth_pkg::ADDR_CONTROL, 32'h83 | (i << 4));
      n0 = npulse;
      while (npulse < n0 + 3) @(posedge pclk);
      chk(32'(gap), 32'h8 << i);
    end
    wr(pth_pkg::ADDR_CONTROL, 32'h0);
    rd(pth_pkg::ADDR_STATUS); chk(32'(d[0]), 32'h1);
    chk(32'(period_irq), 32'h1);
    wr(pth_pkg::ADDR_STATUS, 32'h1);
    @(posedge pclk);
    chk(32'(period_irq), 32'h0);
    wr(pth_pkg::ADDR_COUNT, 32'h3);
    wr(pth_pkg::ADDR_CONTROL, 32'h0);
    rd(pth_pkg::ADDR_COUNT); chk(d, 32'h3);
    wr(pth_pkg::ADDR_LIMIT, 32'h08);
    wr(pth_pkg::ADDR_PERIOD, 32'h3);
    wr(pth_pkg::ADDR_COUNT, 32'h0);
    n0 = npulse;
    wr(pth_pkg::ADDR_CONTROL, 32'h80);
    repeat (30) @(posedge pclk);
    rd(pth_pkg::ADDR_COUNT); chk(d, 32'h0);
    rd(pth_pkg::ADDR_STATUS); chk(32'(d[1]), 32'h0);
    chk(32'(npulse - n0), 32'h1);
    wr(pth_pkg::ADDR_LIMIT, 32'h11);
    wr(pth_pkg::ADDR_EXTSEL, 32'h0);
    n0 = npulse;
    wr(pth_pkg::ADDR_CONTROL, 32'h80);
    repeat (30) @(posedge pclk);
    chk(32'(npulse - n0), 32'h0);
    for (int k = 1; k <= 2; k++) begin
      want <= 1'b1;
      repeat (40) @(posedge pclk);
      chk(32'(npulse - n0), 32'(k));
      want <= 1'b0;
      repeat (10) @(posedge pclk);
    end
    rd(pth_pkg::ADDR_STATUS); chk(32'(d[1]), 32'h1);
    rd(pth_pkg::ADDR_COUNT); chk(d, 32'h0);
    want <= 1'b1;
    wr(pth_pkg::ADDR_CONTROL, 32'h0);
    wr(pth_pkg::ADDR_LIMIT, 32'h07);
    wr(pth_pkg::ADDR_PERIOD, 32'hFF);
    wr(pth_pkg::ADDR_CONTROL, 32'h80);
    repeat (20) @(posedge pclk);
    rd(pth_pkg::ADDR_COUNT); chk(d, 32'h0);
    want <= 1'b0;
    repeat (20) @(posedge pclk);
    rd(pth_pkg::ADDR_COUNT); chk(32'(d != 0), 32'h1);
    dbg <= 1'b1;
    want <= 1'b1;
    repeat (20) @(posedge pclk);
    rd(pth_pkg::ADDR_COUNT); chk(32'(d != 0), 32'h1);
    dbg <= 1'b0;
    repeat (20) @(posedge pclk);
    rd(pth_pkg::ADDR_COUNT); chk(d, 32'h0);
    wr(pth_pkg::ADDR_LIMIT, 32'h01);
    want <= 1'b0;
    repeat (20) @(posedge pclk);
    rd(pth_pkg::ADDR_COUNT);
    e = d;
    repeat (10) @(posedge pclk);
    rd(pth_pkg::ADDR_COUNT); chk(d, e);
    wr(pth_pkg::ADDR_LIMIT, 32'h04);
    repeat (20) @(posedge pclk);
    want <= 1'b1;
    repeat (10) @(posedge pclk);
    rd(pth_pkg::ADDR_COUNT); chk(32'(d < 32'h8), 32'h1);
    wr(pth_pkg::ADDR_CONTROL, 32'h0);
    wr(pth_pkg::ADDR_LIMIT, 32'h09);
    wr(pth_pkg::ADDR_PERIOD, 32'h3);
    wr(pth_pkg::ADDR_COUNT, 32'h0);
    n0 = npulse;
    wr(pth_pkg::ADDR_CONTROL, 32'h80);
    repeat (20) @(posedge pclk);
    chk(32'(npulse - n0), 32'h0);
    want <= 1'b0;
    repeat (10) @(posedge pclk);
    want <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(32'(npulse - n0), 32'h1);
    chk(32'(cnt), 32'h0);
    print_verdict;
  end
endmodule : pth_timer_tb
bind pth_timer pth_timer_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .postscaled_out(postscaled_out),
  .period_irq(period_irq), .timer_count(timer_count), .timer_clock(timer_clock), .period_match(period_match),
  .timer_reset_pulse(timer_reset_pulse));
